// *** hw/rsc_pkg.sv ***
// Shared constants and types for the reset strap configuration capture block
package rsc_pkg;
   // Pad group layout
   localparam int STRAP_W = 8;
   localparam int PLL_W = 3;
   localparam int PAD_W = STRAP_W + 2 * PLL_W;
   localparam int PLAT_LSB = STRAP_W;
   localparam int CORE_LSB = STRAP_W + PLL_W;
   localparam int AD_W = 32;
   // Strap bit that enables the parallel bus arbiter, high is the default
   localparam int STRAP_ARB_BIT = 0;

   // Values after reset: every captured bit reads as its default level
   localparam logic [STRAP_W-1:0] STRAP_RESET = 8'hff;
   localparam logic [PLL_W-1:0] PLL_RESET = 3'h7;

   // Pull-up hold window after hard reset release
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PULLUP_HOLD_NS = 32;
   localparam int HOLD_CYC = (PULLUP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_CNT_W = 4;
   localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = 4'(HOLD_CYC - 1);

   // Test port reset by clocking TMS high
   localparam int TAP_CNT_W = 3;
   localparam logic [TAP_CNT_W-1:0] TAP_TLR_ONES = 3'h5;

   // Register map, byte offsets
   localparam logic [7:0] OFS_DEV_DISABLE = 8'h00;
   localparam logic [7:0] OFS_STRAP_STATUS = 8'h04;
   localparam logic [7:0] OFS_RESET_STATUS = 8'h08;
   localparam int DIS_PBUS_BIT = 0;
   localparam logic DIS_PBUS_RESET = 1'b0;
   localparam int RST_PENDING_BIT = 0;
   localparam int RST_TAP_BIT = 1;
   localparam int RST_ARB_BIT = 2;

   // Captured configuration as seen by the rest of the chip
   typedef struct packed {
      logic [PLL_W-1:0] core_pll;
      logic [PLL_W-1:0] plat_pll;
      logic [STRAP_W-1:0] strap;
   } rsc_cfg_type;
endpackage

// *** hw/rsc_strap_cell.sv ***
// Capture register for one group of strap pads
`timescale 1ns/1ps
module rsc_strap_cell #(
   parameter int W = 8,
   parameter logic [W-1:0] RESET_VAL = '1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Capture control and pad levels
   input wire logic sample_en,
   input wire logic [W-1:0] pin_i,
   // Captured value
   output logic [W-1:0] value_reg
);

   // Tracks the pad through reset so the last asserted level is kept
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         value_reg <= RESET_VAL;
      else if (sample_en)
         value_reg <= pin_i;
   end

   property p_cell_frozen;
      @(posedge clk) disable iff (!rst_b)
      !sample_en |=> $stable(value_reg);
   endproperty
   a_cell_frozen: assert property (p_cell_frozen) else $error("strap value moved outside reset");

   property p_cell_follow;
      @(posedge clk) disable iff (!rst_b)
      sample_en |=> (value_reg == $past(pin_i));
   endproperty
   a_cell_follow: assert property (p_cell_follow) else $error("strap value missed pad level");
endmodule

// *** hw/rsc_tap_reset.sv ***
// Test port reset tracker: reset pin or five TMS-high clocks
`timescale 1ns/1ps
module rsc_tap_reset (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Test port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic trst_n,
   // Test logic held in reset
   output logic tap_reset_reg
);

   logic tck_prev_reg;
   logic [rsc_pkg::TAP_CNT_W-1:0] ones_reg;
   logic [rsc_pkg::TAP_CNT_W-1:0] ones_next;
   wire tck_rise = tck & ~tck_prev_reg;
   wire ones_full = (ones_reg == rsc_pkg::TAP_TLR_ONES);

   // Any state reaches test reset after five TMS-high clocks
   assign ones_next = !trst_n ? rsc_pkg::TAP_TLR_ONES :
                      !tck_rise ? ones_reg :
                      !tms ? '0 :
                      ones_full ? ones_reg : ones_reg + 3'h1;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         tck_prev_reg <= 1'b0;
         ones_reg <= rsc_pkg::TAP_TLR_ONES;
         tap_reset_reg <= 1'b1;
      end
      else
      begin
         tck_prev_reg <= tck;
         ones_reg <= ones_next;
         tap_reset_reg <= (ones_next == rsc_pkg::TAP_TLR_ONES);
      end
   end

   property p_tap_five;
      @(posedge clk) disable iff (!rst_b)
      (tck_rise && tms && trst_n && ones_reg == 3'h4) |=> tap_reset_reg;
   endproperty
   a_tap_five: assert property (p_tap_five) else $error("fifth TMS-high clock did not reset");

   property p_tap_leave;
      @(posedge clk) disable iff (!rst_b)
      (tck_rise && !tms && trst_n) |=> !tap_reset_reg;
   endproperty
   a_tap_leave: assert property (p_tap_leave) else $error("TMS low did not leave test reset");

   property p_tap_trst;
      @(posedge clk) disable iff (!rst_b)
      !trst_n |=> tap_reset_reg;
   endproperty
   a_tap_trst: assert property (p_tap_trst) else $error("reset pin did not reset test logic");
endmodule

// *** hw/rsc_top.sv ***
// Reset strap capture, pad control, test reset and soft reset handling
//
// Summary of operation
// - While hard reset is low, strap pads are inputs with drivers off.
// - Release of hard reset latches strap levels, then pads return to output use.
// - Strap pull-ups stay on through reset and a short window after release.
// - Receiver and pull-up of each strap pad switch off together.
// - A high sampled strap means default; pull-downs select other options.
// - PLL ratio strap pads never get a pull-up.
// - Test logic also resets after five TMS-high TCK edges.
// - Arbiter strapped on: address/data pads driven to stable levels after reset.
// - Arbiter strapped off: address/data pads stay inputs.
// - Software can disable the parallel bus unit, which then stays inactive.
// - Soft reset raises a machine check pulse, not a hard reset.
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module rsc_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Reset and debug pins
   input wire logic HARD_RESET_N,
   input wire logic SOFT_RESET_N,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TRST_N,
   // Strap pads
   input wire logic [rsc_pkg::PAD_W-1:0] PAD_I,
   input wire logic [rsc_pkg::PAD_W-1:0] FUNC_O,
   output logic [rsc_pkg::PAD_W-1:0] PAD_O,
   output logic [rsc_pkg::PAD_W-1:0] PAD_OE,
   output logic [rsc_pkg::PAD_W-1:0] PAD_RX_EN,
   output logic [rsc_pkg::PAD_W-1:0] PAD_PULLUP_EN,
   // Parallel bus address/data pads
   input wire logic [rsc_pkg::AD_W-1:0] FUNC_AD_O,
   output logic [rsc_pkg::AD_W-1:0] AD_O,
   output logic [rsc_pkg::AD_W-1:0] AD_OE,
   output logic PBUS_ACTIVE,
   // Core side
   output rsc_pkg::rsc_cfg_type CFG,
   output logic MACHINE_CHECK,
   output logic TAP_RESET,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);

   typedef enum logic [1:0] {ST_RESET, ST_HOLD, ST_RUN} rsc_state_type;

   rsc_state_type state_reg;
   rsc_state_type state_next;
   logic [rsc_pkg::HOLD_CNT_W-1:0] hold_cnt_reg;
   logic [rsc_pkg::HOLD_CNT_W-1:0] hold_cnt_next;
   logic [rsc_pkg::STRAP_W-1:0] strap_val;
   logic [rsc_pkg::PLL_W-1:0] plat_val;
   logic [rsc_pkg::PLL_W-1:0] core_val;
   rsc_pkg::rsc_cfg_type cfg_q;
   logic tap_reset_w;
   logic soft_prev_reg;
   logic dis_pbus_reg;
   logic dis_pbus_next;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;

   // Capture runs while hard reset is low; pads are assumed synchronous
   wire capture_en = ~HARD_RESET_N;

   rsc_strap_cell #(.W(rsc_pkg::STRAP_W), .RESET_VAL(rsc_pkg::STRAP_RESET)) u_strap (
      .clk(CLK),
      .rst_b(RST_B),
      .sample_en(capture_en),
      .pin_i(PAD_I[rsc_pkg::STRAP_W-1:0]),
      .value_reg(strap_val)
   );

   rsc_strap_cell #(.W(rsc_pkg::PLL_W), .RESET_VAL(rsc_pkg::PLL_RESET)) u_plat_pll (
      .clk(CLK),
      .rst_b(RST_B),
      .sample_en(capture_en),
      .pin_i(PAD_I[rsc_pkg::PLAT_LSB +: rsc_pkg::PLL_W]),
      .value_reg(plat_val)
   );

   rsc_strap_cell #(.W(rsc_pkg::PLL_W), .RESET_VAL(rsc_pkg::PLL_RESET)) u_core_pll (
      .clk(CLK),
      .rst_b(RST_B),
      .sample_en(capture_en),
      .pin_i(PAD_I[rsc_pkg::CORE_LSB +: rsc_pkg::PLL_W]),
      .value_reg(core_val)
   );

   rsc_tap_reset u_tap (
      .clk(CLK),
      .rst_b(RST_B),
      .tck(TCK),
      .tms(TMS),
      .trst_n(TRST_N),
      .tap_reset_reg(tap_reset_w)
   );

   // Straight from the capture flops, so the core never sees a mid-capture mix
   assign cfg_q = '{core_pll: core_val, plat_pll: plat_val, strap: strap_val};
   assign CFG = cfg_q;
   assign TAP_RESET = tap_reset_w;

   // Sequencer: reset, pull-up hold window, normal run
   wire hold_done = (hold_cnt_reg == rsc_pkg::HOLD_LAST);
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET:
            state_next = HARD_RESET_N ? ST_HOLD : ST_RESET;
         ST_HOLD:
            state_next = !HARD_RESET_N ? ST_RESET : (hold_done ? ST_RUN : ST_HOLD);
         ST_RUN:
            state_next = HARD_RESET_N ? ST_RUN : ST_RESET;
         default:
            state_next = ST_RESET;
      endcase
   end
   assign hold_cnt_next = (state_next == ST_HOLD && state_reg == ST_HOLD) ?
                          hold_cnt_reg + 4'h1 : '0;

   // Pad modes follow the next state so outputs change on the same edge
   wire input_mode = (state_next != ST_RUN);
   wire [rsc_pkg::PAD_W-1:0] pullup_mask = {{(2 * rsc_pkg::PLL_W){1'b0}},
                                            {rsc_pkg::STRAP_W{1'b1}}};
   wire [rsc_pkg::PAD_W-1:0] rx_en_next = {rsc_pkg::PAD_W{input_mode}};
   wire [rsc_pkg::PAD_W-1:0] pullup_next = rx_en_next & pullup_mask;

   // Parallel bus pad behaviour set by the captured arbiter strap
   wire arb_en = cfg_q.strap[rsc_pkg::STRAP_ARB_BIT];
   wire ad_drive_next = (state_next == ST_RUN) && arb_en;
   wire pbus_active_next = (state_next == ST_RUN) && !dis_pbus_next;
   // A disabled unit parks its pads at zero when the arbiter strap is on; with it off they float
   wire [rsc_pkg::AD_W-1:0] ad_o_next = pbus_active_next ? FUNC_AD_O : '0;

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         state_reg <= ST_RESET;
         hold_cnt_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         PAD_O <= '0;
         PAD_OE <= '0;
         PAD_RX_EN <= '1;
         PAD_PULLUP_EN <= pullup_mask;
         AD_O <= '0;
         AD_OE <= '0;
         PBUS_ACTIVE <= 1'b0;
      end
      else
      begin
         PAD_O <= FUNC_O;
         PAD_OE <= ~rx_en_next;
         PAD_RX_EN <= rx_en_next;
         PAD_PULLUP_EN <= pullup_next;
         AD_O <= ad_o_next;
         AD_OE <= {rsc_pkg::AD_W{ad_drive_next}};
         PBUS_ACTIVE <= pbus_active_next;
      end
   end

   // Soft reset only signals the core; sequencer and straps are untouched
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         soft_prev_reg <= 1'b1;
         MACHINE_CHECK <= 1'b0;
      end
      else
      begin
         soft_prev_reg <= SOFT_RESET_N;
         MACHINE_CHECK <= soft_prev_reg & ~SOFT_RESET_N;
      end
   end

   // AHB-Lite slave, zero wait states, always OKAY
   wire addr_take = HSEL & HTRANS[1] & HREADY;
   wire wr_dev_dis = wr_pend_reg && (wr_addr_reg == rsc_pkg::OFS_DEV_DISABLE);
   // Hard reset clears the disable bit and blocks writes to it
   assign dis_pbus_next = !HARD_RESET_N ? rsc_pkg::DIS_PBUS_RESET :
                          wr_dev_dis ? HWDATA[rsc_pkg::DIS_PBUS_BIT] : dis_pbus_reg;
   // Reads use the next value so a read right after a write sees it
   wire [31:0] dev_dis_word = {31'h0, dis_pbus_next};
   wire [31:0] strap_word = {18'h0, cfg_q};
   wire [31:0] rst_word = {29'h0, arb_en, tap_reset_w, state_reg != ST_RUN};
   wire [7:0] rd_ofs = HADDR[7:0];
   wire [31:0] rd_word = (rd_ofs == rsc_pkg::OFS_DEV_DISABLE) ? dev_dis_word :
                         (rd_ofs == rsc_pkg::OFS_STRAP_STATUS) ? strap_word :
                         (rd_ofs == rsc_pkg::OFS_RESET_STATUS) ? rst_word : 32'h0;

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         dis_pbus_reg <= rsc_pkg::DIS_PBUS_RESET;
         HRDATA <= '0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
      else
      begin
         wr_pend_reg <= addr_take & HWRITE;
         wr_addr_reg <= HADDR[7:0];
         dis_pbus_reg <= dis_pbus_next;
         HRDATA <= (addr_take & ~HWRITE) ? rd_word : 32'h0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   property p_reset_inputs;
      @(posedge CLK) disable iff (!RST_B)
      !HARD_RESET_N |=> (PAD_OE == '0) && (PAD_RX_EN == '1);
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("strap pad driven in reset");

   property p_release;
      @(posedge CLK) disable iff (!RST_B)
      $rose(HARD_RESET_N) ##1 HARD_RESET_N [*8] |=> (PAD_OE == '1) && (PAD_RX_EN == '0);
   endproperty
   a_release: assert property (p_release) else $error("pads not returned after hold window");

   property p_pullup_hold;
      @(posedge CLK) disable iff (!RST_B)
      $rose(HARD_RESET_N) |-> PAD_PULLUP_EN[0] [*8];
   endproperty
   a_pullup_hold: assert property (p_pullup_hold) else $error("pull-up dropped too early");

   property p_pullup_with_rx;
      @(posedge CLK) disable iff (!RST_B)
      (PAD_PULLUP_EN & ~PAD_RX_EN) == '0;
   endproperty
   a_pullup_with_rx: assert property (p_pullup_with_rx) else $error("pull-up on with receiver off");

   property p_pll_no_pullup;
      @(posedge CLK) disable iff (!RST_B)
      PAD_PULLUP_EN[rsc_pkg::PAD_W-1:rsc_pkg::PLAT_LSB] == '0;
   endproperty
   a_pll_no_pullup: assert property (p_pll_no_pullup) else $error("pull-up on a PLL ratio pad");

   property p_ad_driven;
      @(posedge CLK) disable iff (!RST_B)
      (state_reg == ST_RUN && arb_en) |-> (AD_OE == '1);
   endproperty
   a_ad_driven: assert property (p_ad_driven) else $error("bus pads not driven with arbiter on");

   property p_ad_input;
      @(posedge CLK) disable iff (!RST_B)
      !arb_en |-> (AD_OE == '0);
   endproperty
   a_ad_input: assert property (p_ad_input) else $error("bus pads driven with arbiter off");

   property p_pbus_off;
      @(posedge CLK) disable iff (!RST_B)
      dis_pbus_reg |-> !PBUS_ACTIVE && (AD_O == '0);
   endproperty
   a_pbus_off: assert property (p_pbus_off) else $error("disabled bus unit still active");

   property p_machine_check;
      @(posedge CLK) disable iff (!RST_B)
      $fell(SOFT_RESET_N) |=> MACHINE_CHECK ##1 !MACHINE_CHECK;
   endproperty
   a_machine_check: assert property (p_machine_check) else $error("soft reset pulse wrong");

   property p_cfg_stable;
      @(posedge CLK) disable iff (!RST_B)
      (state_reg != ST_RESET && HARD_RESET_N) |=> $stable(cfg_q);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("configuration changed outside reset");
endmodule

// *** verification/reset_strap_config_capture_tb.sv ***
// Testbench for the reset strap configuration capture block
`timescale 1ns/1ps
module reset_strap_config_capture_tb;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic SOFT_RESET_N = 1'b1;
   logic TCK = 1'b0;
   logic TMS = 1'b0;
   logic [13:0] FUNC_O = 14'h2c71;
   logic [31:0] FUNC_AD_O = 32'h5a5ac3c3;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h0;
   logic [13:0] board_lvl = 14'h3fff;
   logic por_n = 1'b0;
   logic dbg_hard_reset_n_n = 1'b1;
   logic wdog_n = 1'b1;
   logic dbg_trst_n = 1'b1;
   logic HARD_RESET_N, TRST_N, PBUS_ACTIVE, MACHINE_CHECK, TAP_RESET, HREADYOUT, HRESP;
   logic [13:0] PAD_I, PAD_O, PAD_OE, PAD_RX_EN, PAD_PULLUP_EN;
   logic [31:0] AD_O, AD_OE, HRDATA, rd;
   rsc_pkg::rsc_cfg_type CFG;
   logic [13:0] lvls [3] = '{14'h3fff, 14'h2b52, 14'h15ad};
   int failures = 0;
   int total_checks = 0;
   int pulses;

   always #2 CLK = ~CLK;

   rsc_board_model board (.clk(CLK), .board_lvl(board_lvl), .por_n(por_n),
      .dbg_hard_reset_n_n(dbg_hard_reset_n_n), .wdog_n(wdog_n), .dbg_trst_n(dbg_trst_n),
      .pad_oe(PAD_OE), .pad_o(PAD_O), .pullup_en(PAD_PULLUP_EN), .pad_i(PAD_I),
      .hard_reset_n(HARD_RESET_N), .trst_n(TRST_N));

   rsc_top uut (.CLK(CLK), .RST_B(RST_B), .HARD_RESET_N(HARD_RESET_N),
      .SOFT_RESET_N(SOFT_RESET_N), .TCK(TCK), .TMS(TMS), .TRST_N(TRST_N),
      .PAD_I(PAD_I), .FUNC_O(FUNC_O), .PAD_O(PAD_O), .PAD_OE(PAD_OE),
      .PAD_RX_EN(PAD_RX_EN), .PAD_PULLUP_EN(PAD_PULLUP_EN), .FUNC_AD_O(FUNC_AD_O),
      .AD_O(AD_O), .AD_OE(AD_OE), .PBUS_ACTIVE(PBUS_ACTIVE), .CFG(CFG),
      .MACHINE_CHECK(MACHINE_CHECK), .TAP_RESET(TAP_RESET), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP));

   task tick(input int n);
      repeat (n) @(posedge CLK);
   endtask

   // Checks sit at the falling edge, well clear of the launch edge
   task look;
      @(negedge CLK);
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Single word transfer; the master never assumes the wait count
   task ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
      output logic [31:0] rdata);
      @(posedge CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, addr};
      HWRITE <= wr;
      HSIZE <= 3'h2;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rdata = HRDATA;
      chk(32'(HRESP), 32'h0, "bus response");
   endtask

   task tck_pulse(input logic m);
      @(posedge CLK);
      TMS <= m;
      TCK <= 1'b1;
      @(posedge CLK);
      TCK <= 1'b0;
      @(posedge CLK);
   endtask

   task end_test(input string name);
      $display("test %s finished", name);
   endtask

   task strap_run(input logic [13:0] lvl, input int src);
      @(posedge CLK);
      board_lvl <= lvl;
      if (src == 0) por_n <= 1'b0;
      else if (src == 1) dbg_hard_reset_n_n <= 1'b0;
      else wdog_n <= 1'b0;
      tick(3);
      look;
      chk(32'(PAD_OE), 32'h0, "pads driven in reset");
      chk(32'(PAD_RX_EN), 32'h3fff, "receivers in reset");
      chk(32'(PAD_PULLUP_EN), 32'h00ff, "pull-ups in reset");
      ahb(1'b1, rsc_pkg::OFS_DEV_DISABLE, 32'h1, rd);
      ahb(1'b0, rsc_pkg::OFS_DEV_DISABLE, 32'h0, rd);
      chk(rd, 32'h0, "disable write in reset");
      @(posedge CLK);
      por_n <= 1'b1;
      dbg_hard_reset_n_n <= 1'b1;
      wdog_n <= 1'b1;
      // A short watchdog pulse inside the hold window restarts it
      tick(3);
      look;
      chk(32'(PAD_OE), 32'h0, "pads in hold");
      @(posedge CLK);
      wdog_n <= 1'b0;
      @(posedge CLK);
      wdog_n <= 1'b1;
      tick(8);
      look;
      chk(32'(PAD_OE), 32'h0, "pads late in hold");
      chk(32'(PAD_PULLUP_EN), 32'h00ff, "pull-ups in hold");
      tick(1);
      look;
      chk(32'(PAD_OE), 32'h3fff, "pads after hold");
      chk(32'(PAD_RX_EN), 32'h0, "receivers after hold");
      chk(32'(PAD_PULLUP_EN), 32'h0, "pull-ups after hold");
      chk(32'(CFG), 32'(lvl), "captured straps");
      chk(AD_OE, lvl[0] ? 32'hffffffff : 32'h0, "address/data drive");
      chk(32'(PAD_O), 32'(FUNC_O), "pad function data");
      @(posedge CLK);
      board_lvl <= ~lvl;
      tick(4);
      look;
      chk(32'(CFG), 32'(lvl), "straps held in run");
   endtask

   task test_done;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      tick(5);
      RST_B <= 1'b1;
      for (int i = 0; i < 3; i++)
         strap_run(lvls[i], i);
      end_test("strap");
      ahb(1'b1, rsc_pkg::OFS_DEV_DISABLE, 32'h1, rd);
      ahb(1'b0, rsc_pkg::OFS_DEV_DISABLE, 32'h0, rd);
      chk(rd, 32'h1, "disable readback");
      look;
      chk(32'(PBUS_ACTIVE), 32'h0, "bus unit held off");
      chk(AD_O, 32'h0, "address/data idle");
      ahb(1'b0, rsc_pkg::OFS_STRAP_STATUS, 32'h0, rd);
      chk(rd, 32'h15ad, "strap status");
      ahb(1'b0, rsc_pkg::OFS_RESET_STATUS, 32'h0, rd);
      chk(rd, 32'h6, "reset status");
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      ahb(1'b1, rsc_pkg::OFS_DEV_DISABLE, 32'h0, rd);
      look;
      chk(32'(PBUS_ACTIVE), 32'h1, "bus unit back on");
      chk(AD_O, FUNC_AD_O, "address/data driven");
      end_test("bus");
      @(posedge CLK);
      SOFT_RESET_N <= 1'b0;
      pulses = 0;
      repeat (8)
      begin
         look;
         if (MACHINE_CHECK === 1'b1) pulses++;
      end
      @(posedge CLK);
      SOFT_RESET_N <= 1'b1;
      chk(32'(pulses), 32'h1, "machine check pulses");
      chk(32'(PAD_OE), 32'h3fff, "no hard reset from soft");
      end_test("soft");
      tck_pulse(1'b0);
      look;
      chk(32'(TAP_RESET), 32'h0, "test logic leaves reset");
      repeat (4) tck_pulse(1'b1);
      look;
      chk(32'(TAP_RESET), 32'h0, "four TMS-high clocks");
      tck_pulse(1'b1);
      look;
      chk(32'(TAP_RESET), 32'h1, "five TMS-high clocks");
      tck_pulse(1'b0);
      @(posedge CLK);
      dbg_trst_n <= 1'b0;
      tick(2);
      look;
      chk(32'(TAP_RESET), 32'h1, "debug test reset");
      chk(32'(HARD_RESET_N), 32'h1, "hard reset untouched");
      @(posedge CLK);
      dbg_trst_n <= 1'b1;
      end_test("tap");
      test_done;
   end

   // Whole run takes well under a microsecond; this is far beyond it
   initial
   begin
      #100000;
      failures++;
      $display("mismatch at %0t: run did not complete", $time);
      test_done;
   end
endmodule

// *** verification/rsc_board_model.sv ***
// Board model: strap resistors on the pads and merged reset sources
`timescale 1ns/1ps
module rsc_board_model (
   // Clock
   input wire logic clk,
   // Board resistor levels and reset sources
   input wire logic [13:0] board_lvl,
   input wire logic por_n,
   input wire logic dbg_hard_reset_n_n,
   input wire logic wdog_n,
   input wire logic dbg_trst_n,
   // Device pad controls
   input wire logic [13:0] pad_oe,
   input wire logic [13:0] pad_o,
   input wire logic [13:0] pullup_en,
   output logic [13:0] pad_i,
   // Merged reset pins
   output logic hard_reset_n,
   output logic trst_n
);
   logic [13:0] last_lvl;
   logic [13:0] pull_up;
   // A low board level means a pull-down is fitted
   // Ratio pads lean only on board resistors, never on the chip
   assign pull_up = pullup_en | {board_lvl[13:8], 8'h00};
   // Undriven pad with no pull shows the inverse of its last level
   assign pad_i = (pad_oe & pad_o) | (~pad_oe & board_lvl & (pull_up | ~last_lvl));
   always @(posedge clk)
   begin
      last_lvl <= pad_i;
   end
   // Any source may assert hard reset without the others
   assign hard_reset_n = por_n & dbg_hard_reset_n_n & wdog_n;
   assign trst_n = por_n & dbg_trst_n;
endmodule
